// [rtl/hmcs_sequencer.sv]
// measurement cycle sequencer: walks the enabled channels and stores results
// assumes ctrl and the adc sample are synchronous to ref_clk; trigger is a pulse
`timescale 1ns/10ps
`include "hmcs_cfg.svh"
module hmcs_sequencer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire hmcs_pkg::hmcs_ctrl_s ctrl,
  input wire logic trigger,
  input wire hmcs_pkg::hmcs_word_t adcSample,
  output hmcs_pkg::hmcs_result_s result,
  output logic [4:0] convActive,
  output logic resultValid,
  output logic cycleDone
);
  hmcs_pkg::hmcs_state_e state_q, state_d;
  logic [`HMCS_CNT_W-1:0] cnt_q, cnt_d;
  hmcs_pkg::hmcs_result_s res_q, res_d;
  logic valid_q, valid_d;
  logic done_q, done_d;

  // temperature is on unless the channel config or the enable drops it
  function automatic logic doTemp(input hmcs_pkg::hmcs_ctrl_s c);
    doTemp = (c.chanCfg == `HMCS_CFG_XYZT) && c.tempEnable;
  endfunction

  function automatic logic [`HMCS_CNT_W-1:0] convLen(input logic isAxis,
                                                    input hmcs_pkg::hmcs_ctrl_s c);
    if (isAxis && c.shortRange) begin
      convLen = `HMCS_CNT_W'(`HMCS_CYC_SHORT - 1);
    end else begin
      convLen = `HMCS_CNT_W'(`HMCS_CYC_FULL - 1);
    end
  endfunction

  logic convEnd;
  assign convEnd = (state_q != hmcs_pkg::HMCS_IDLE) && (cnt_q == '0);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    res_d = res_q;
    valid_d = 1'b0;
    done_d = 1'b0;
    if (state_q != hmcs_pkg::HMCS_IDLE && cnt_q != '0) begin
      cnt_d = cnt_q - `HMCS_CNT_W'(1);
    end
    case (state_q)
      hmcs_pkg::HMCS_IDLE: begin
        // ctrl is sampled again at every channel start, so a change mid-cycle can mix ranges within one cycle
        if (ctrl.fastMode || trigger) begin
          state_d = hmcs_pkg::HMCS_CONV_X;
          cnt_d = convLen(1'b1, ctrl);
        end
      end
      hmcs_pkg::HMCS_CONV_X: begin
        if (convEnd) begin
          res_d.x = adcSample;
          valid_d = 1'b1;
          state_d = hmcs_pkg::HMCS_CONV_Y;
          cnt_d = convLen(1'b1, ctrl);
        end
      end
      hmcs_pkg::HMCS_CONV_Y: begin
        if (convEnd) begin
          res_d.y = adcSample;
          valid_d = 1'b1;
          if (ctrl.chanCfg == `HMCS_CFG_XY) begin
            state_d = hmcs_pkg::HMCS_IDLE;
            done_d = 1'b1;
          end else begin
            state_d = hmcs_pkg::HMCS_CONV_Z;
            cnt_d = convLen(1'b1, ctrl);
          end
        end
      end
      hmcs_pkg::HMCS_CONV_Z: begin
        if (convEnd) begin
          res_d.z = adcSample;
          valid_d = 1'b1;
          if (doTemp(ctrl)) begin
            state_d = hmcs_pkg::HMCS_CONV_T;
            cnt_d = convLen(1'b0, ctrl);
          end else begin
            state_d = hmcs_pkg::HMCS_IDLE;
            done_d = 1'b1;
          end
        end
      end
      hmcs_pkg::HMCS_CONV_T: begin
        if (convEnd) begin
          res_d.t = adcSample;
          valid_d = 1'b1;
          state_d = hmcs_pkg::HMCS_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = hmcs_pkg::HMCS_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= hmcs_pkg::HMCS_IDLE;
      cnt_q <= '0;
      res_q <= '0;
      valid_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      valid_q <= valid_d;
      done_q <= done_d;
    end
  end

  assign result = res_q;
  assign convActive = state_q;
  assign resultValid = valid_q;
  assign cycleDone = done_q;

  // checks
  a_fast_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && done_q && ctrl.fastMode |-> ##1 state_q == hmcs_pkg::HMCS_CONV_X || !$past(clkEn))
    else $error("fast mode did not restart");
  a_idle_no_trig: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == hmcs_pkg::HMCS_IDLE && !ctrl.fastMode && !trigger |=>
    state_q == hmcs_pkg::HMCS_IDLE)
    else $error("cycle started without trigger");
  a_trig_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && state_q == hmcs_pkg::HMCS_IDLE && trigger |=> state_q == hmcs_pkg::HMCS_CONV_X)
    else $error("trigger ignored");
  a_x_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && state_q == hmcs_pkg::HMCS_IDLE && trigger && !ctrl.shortRange |=>
    cnt_q == `HMCS_CNT_W'(`HMCS_CYC_FULL - 1))
    else $error("full range length wrong");
  a_short_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && state_q == hmcs_pkg::HMCS_IDLE && trigger && ctrl.shortRange |=>
    cnt_q == `HMCS_CNT_W'(`HMCS_CYC_SHORT - 1))
    else $error("short range length wrong");
  a_t_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && convEnd && state_q == hmcs_pkg::HMCS_CONV_T |=>
    done_q && state_q == hmcs_pkg::HMCS_IDLE)
    else $error("cycle did not end after temperature");
  a_z_skip_t: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && convEnd && state_q == hmcs_pkg::HMCS_CONV_Z && ctrl.chanCfg == `HMCS_CFG_XYZ |=>
    done_q && $stable(res_q.t))
    else $error("three channel cycle wrong");
  a_xy_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && convEnd && state_q == hmcs_pkg::HMCS_CONV_Y && ctrl.chanCfg == `HMCS_CFG_XY |=>
    done_q && $stable(res_q.z) && $stable(res_q.t))
    else $error("angular cycle wrong");
  a_x_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && convEnd && state_q == hmcs_pkg::HMCS_CONV_X |=>
    res_q.x == $past(adcSample) && state_q == hmcs_pkg::HMCS_CONV_Y)
    else $error("x result or order wrong");

  // remaining channels, their order and the temperature switch
  a_y_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && convEnd && state_q == hmcs_pkg::HMCS_CONV_Y |=> res_q.y == $past(adcSample))
    else $error("y result wrong");
  a_z_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && convEnd && state_q == hmcs_pkg::HMCS_CONV_Z |=> res_q.z == $past(adcSample))
    else $error("z result wrong");
  a_t_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && convEnd && state_q == hmcs_pkg::HMCS_CONV_T |=> res_q.t == $past(adcSample))
    else $error("temperature result wrong");
  a_y_to_z: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && convEnd && state_q == hmcs_pkg::HMCS_CONV_Y && ctrl.chanCfg != `HMCS_CFG_XY |=>
    state_q == hmcs_pkg::HMCS_CONV_Z)
    else $error("z did not follow y");
  a_z_to_t: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && convEnd && state_q == hmcs_pkg::HMCS_CONV_Z && ctrl.chanCfg == `HMCS_CFG_XYZT &&
    ctrl.tempEnable |=> state_q == hmcs_pkg::HMCS_CONV_T)
    else $error("temperature not converted");
  a_temp_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && convEnd && state_q == hmcs_pkg::HMCS_CONV_Z && ctrl.chanCfg == `HMCS_CFG_XYZT &&
    ctrl.tempEnable |=> cnt_q == `HMCS_CNT_W'(`HMCS_CYC_FULL - 1))
    else $error("temperature length wrong");
  a_temp_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && convEnd && state_q == hmcs_pkg::HMCS_CONV_Z && !ctrl.tempEnable |=>
    done_q && state_q == hmcs_pkg::HMCS_IDLE && $stable(res_q.t))
    else $error("disabled temperature converted");
  a_busy_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clkEn && state_q == hmcs_pkg::HMCS_CONV_X && !convEnd |=> state_q == hmcs_pkg::HMCS_CONV_X)
    else $error("conversion cut short");
  a_done_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_q |-> state_q == hmcs_pkg::HMCS_IDLE)
    else $error("cycle end pulse outside idle");
  // a paused cycle must not run short, so every counter holds while clkEn is low
  a_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clkEn |=> $stable(state_q) && $stable(cnt_q) && $stable(res_q))
    else $error("state moved while frozen");

  // main scenarios
  c_full_cycle: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == hmcs_pkg::HMCS_CONV_T && convEnd);
  c_three_cycle: cover property (@(posedge ref_clk) disable iff (!rst_n)
    done_q && ctrl.chanCfg == `HMCS_CFG_XYZ);
  c_xy_cycle: cover property (@(posedge ref_clk) disable iff (!rst_n)
    done_q && ctrl.chanCfg == `HMCS_CFG_XY);
  c_fast_back: cover property (@(posedge ref_clk) disable iff (!rst_n)
    done_q && ctrl.fastMode ##1 state_q == hmcs_pkg::HMCS_CONV_X);
  c_frozen: cover property (@(posedge ref_clk) disable iff (!rst_n)
    !clkEn && state_q != hmcs_pkg::HMCS_IDLE);
endmodule

// [rtl/hmcs_cfg.svh]
// timing and encoding constants for the measurement cycle sequencer
// assumes a 100 MHz ref_clk
`ifndef HMCS_CFG_SVH
`define HMCS_CFG_SVH
`define HMCS_CLK_MHZ 100
`define HMCS_T_FULL_US 43
`define HMCS_T_SHORT_US 59
`define HMCS_CYC_FULL (`HMCS_T_FULL_US * `HMCS_CLK_MHZ)
`define HMCS_CYC_SHORT (`HMCS_T_SHORT_US * `HMCS_CLK_MHZ)
`define HMCS_CNT_W 13
`define HMCS_DATA_W 12
`define HMCS_CFG_XYZT 2'h0
`define HMCS_CFG_XYZ 2'h1
`define HMCS_CFG_XY 2'h2
`endif

// [rtl/hmcs_pkg.sv]
// types for the measurement cycle sequencer
// assumes hmcs_cfg.svh is on the include path
`include "hmcs_cfg.svh"
package hmcs_pkg;
  typedef enum logic [4:0] {
    HMCS_IDLE = 5'h01,
    HMCS_CONV_X = 5'h02,
    HMCS_CONV_Y = 5'h04,
    HMCS_CONV_Z = 5'h08,
    HMCS_CONV_T = 5'h10
  } hmcs_state_e;
  typedef logic [`HMCS_DATA_W-1:0] hmcs_word_t;
  typedef struct packed {
    hmcs_word_t x;
    hmcs_word_t y;
    hmcs_word_t z;
    hmcs_word_t t;
  } hmcs_result_s;
  typedef struct packed {
    logic fastMode;
    logic shortRange;
    logic [1:0] chanCfg;
    logic tempEnable;
  } hmcs_ctrl_s;
endpackage

// [verification/hmcs_host_model.sv]
// host model: triggers cycles and reads every fresh result
// assumes result and resultValid come from hmcs_sequencer on ref_clk
`timescale 1ns/10ps
module hmcs_host_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic resultValid,
  input wire hmcs_pkg::hmcs_result_s result,
  output logic trigger,
  output hmcs_pkg::hmcs_result_s lastRead
);
  // a one-cycle request; go is only raised once reset has let go
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) trigger <= 1'b0;
    else trigger <= go;
  end
  // reads on every update, so fast mode never loses a sample
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) lastRead <= '0;
    else if (resultValid) lastRead <= result;
  end
endmodule

// [verification/hmcs_sequencer_tb.sv]
// self-checking bench for the measurement cycle sequencer
// assumes hmcs_cfg.svh on the include path and the host model beside it
`timescale 1ns/10ps
`include "hmcs_cfg.svh"
module hmcs_sequencer_tb;
  localparam int F = `HMCS_CYC_FULL;
  localparam int S = `HMCS_CYC_SHORT;
  logic ref_clk, rst_n, go, trigger, resultValid, cycleDone, clkEn;
  logic [4:0] convActive;
  hmcs_pkg::hmcs_ctrl_s ctrl;
  hmcs_pkg::hmcs_word_t adcSample;
  hmcs_pkg::hmcs_result_s result, lastRead, expRes;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n, v;
  logic [4:0] rowCtrl [5] = '{5'h01, 5'h03, 5'h05, 5'h00, 5'h0d};
  logic [3:0] rowMask [5] = '{4'hf, 4'he, 4'hc, 4'he, 4'hc};
  int rowLen [5] = '{4*F, 3*F, 2*F, 3*F, 2*S};
  hmcs_sequencer u_hmcs_sequencer (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
    .ctrl(ctrl), .trigger(trigger), .adcSample(adcSample), .result(result),
    .convActive(convActive), .resultValid(resultValid), .cycleDone(cycleDone));
  hmcs_host_model u_hmcs_host_model (.ref_clk(ref_clk), .rst_n(rst_n), .go(go),
    .resultValid(resultValid), .result(result), .trigger(trigger), .lastRead(lastRead));
  task automatic chkVal(input string nm, input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkCnt(input string nm, input int e, input int g);
    chkVal(nm, 48'(e), 48'(g));
  endtask
  // counts edges up to the end-of-cycle pulse; bounded so a stall cannot hang
  task automatic waitDone(output int k, output int v);
    k = 0;
    v = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
      if (resultValid === 1'b1) v++;
      if (k == 1) chkVal("first channel", 48'h02, 48'(convActive));
    end while (cycleDone !== 1'b1 && k < 30000);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // all cycles together take about 81k clocks
  initial begin
    #1_000_000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    clkEn = 1'b1;
    ctrl = 5'h01;
    adcSample = '0;
    expRes = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (100) @(posedge ref_clk);
    #1;
    chkVal("idle without trigger", 48'h01, 48'(convActive));
    chkVal("reset result", expRes, result);
    for (int r = 0; r < 5; r++) begin
      @(posedge ref_clk);
      ctrl <= rowCtrl[r];
      adcSample <= 12'h15a + 12'(r * 'h111);
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      waitDone(n, v);
      chkCnt("cycle length", rowLen[r], n);
      chkCnt("updates", $countones(rowMask[r]), v);
      for (int i = 0; i < 4; i++) if (rowMask[r][i]) expRes[i*12 +: 12] = adcSample;
      chkVal("results", expRes, result);
    end
    // fast mode in angular form: no trigger, back-to-back cycles
    @(posedge ref_clk);
    ctrl <= 5'h15;
    adcSample <= 12'h3c3;
    waitDone(n, v);
    // pause the restarted cycle; the gap must grow by exactly the frozen clocks
    @(posedge ref_clk);
    clkEn <= 1'b0;
    repeat (50) @(posedge ref_clk);
    clkEn <= 1'b1;
    #1;
    chkVal("frozen channel", 48'h02, 48'(convActive));
    waitDone(n, v);
    chkCnt("fast gap", 2*F + 1 + 50, n + 51);
    chkCnt("fast updates", 2, v);
    expRes[47:24] = {12'h3c3, 12'h3c3};
    @(posedge ref_clk);
    #1;
    chkVal("host read", expRes, lastRead);
    // reset in mid-run, then fast mode must pick up again on its own
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    chkVal("mid-run reset state", 48'h01, 48'(convActive));
    chkVal("mid-run reset result", 48'h0, 48'(result));
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chkVal("restart after reset", 48'h02, 48'(convActive));
    end_of_test();
  end
endmodule
